// ---- logic/adcsf_core.v ----
// serial control and readout of a 10-bit successive-approximation converter
// Operation
// - each conversion yields 10 result bits, shifted out on host clock
// - select high keeps output released and converter powered down
// - select falling samples frame sync: low framed, high three-wire
// - frame sync latched twice; three-wire only if both latches see one
// - framed mode stays powered down until frame sync rises
// - frame sync high on shift-clock fall resets and starts sampling
// - frame sync low starts shifting, first zero bit presented
// - framed sampling ends on the rise driving the sixth zero
// - word holds six leading zeros then the result bits
// - one decision per rise, each bit driven one rise later
// - after the last bit power down; next frame sync wakes it
// - frame sync on sixteenth bit gives back-to-back conversions
// - frame sync high mid-conversion aborts and restarts the cycle
// - select high at any time releases output, powers down, aborts
// - select low in framed mode starts frame sync checks on falls
// - three-wire sampling starts first rise after select falls
// - three-wire powers down on sixteenth fall, wakes on next rise
`timescale 1ns/1ns
`include "adcsf_defines.vh"
module adcsf_core (
  input  wire        clock_in,
  input  wire        resetn_in,
  input  wire        sclk_in,
  input  wire        select_n_in,
  input  wire        frame_sync_in,
  input  wire        compare_in,
  output reg         serial_data_out,
  output reg         serial_data_oe_out,
  output reg         powerdown_out,
  output reg         sample_out,
  output reg         spi_mode_out,
  output reg  [9:0]  dac_code_out,
  output reg  [9:0]  result_out,
  output reg         result_valid_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [9:0] trial_mask;
    input [3:0] idx;
    begin
      trial_mask = `ADCSF_CODE_ONE << idx;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  wire [3:0] sync_w;
  wire       sclk_s;
  wire       sel_n_s;
  wire       fs_s;
  wire       cmp_s;
  reg        sclk_d_reg;
  reg        sel_n_d_reg;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       sel_fall;

  // select enters inverted so cleared flops read as deselected, no false edge
  adcsf_sync #(
    .WIDTH (`ADCSF_SYNC_WIDTH)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  ({sclk_in, ~select_n_in, frame_sync_in, compare_in}),
    .sync_out  (sync_w)
  );

  assign sclk_s    = sync_w[3];
  assign sel_n_s   = ~sync_w[2];
  assign fs_s      = sync_w[1];
  assign cmp_s     = sync_w[0];
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign sel_fall  = ~sel_n_s & sel_n_d_reg;

  // select idles high so the first low after reset is an edge
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_d_reg  <= 1'b0;
      sel_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg  <= sclk_s;
      sel_n_d_reg <= sel_n_s;
    end
  end

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_OFF   = `ADCSF_ST_OFF;
  localparam [2:0] ST_MODE  = `ADCSF_ST_MODE;
  localparam [2:0] ST_WAIT  = `ADCSF_ST_WAIT;
  localparam [2:0] ST_RESET = `ADCSF_ST_RESET;
  localparam [2:0] ST_SHIFT = `ADCSF_ST_SHIFT;
  localparam [2:0] ST_PDN   = `ADCSF_ST_PDN;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] bit_cnt_reg;
  reg [3:0] bit_cnt_next;
  reg [3:0] sar_idx_reg;
  reg [3:0] sar_idx_next;
  reg       fs_first_reg;
  reg       fs_first_next;
  reg       spi_next;
  reg       data_next;
  reg       oe_next;
  reg       pd_next;
  reg       sample_next;
  reg [9:0] dac_next;
  reg [9:0] result_next;
  reg       rvalid_next;

  // ----------------------------------------------------------------
  // decision buffer
  // ----------------------------------------------------------------
  // decided bits wait here one bit period before going out; a full
  // buffer holds the bit counter so no decision is ever dropped
  reg  push;
  reg  pop;
  reg  flush;
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_data;

  adcsf_fifo2 #(
    .WIDTH (`ADCSF_BUF_WIDTH)
  ) u_buf (
    .clock_in      (clock_in),
    .resetn_in     (resetn_in),
    .flush_in      (flush),
    .in_valid_in   (push),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (cmp_s),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (pop),
    .out_data_out  (buf_out_data)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  reg [3:0] nxt_bit;
  reg       want_dec;

  always @* begin
    nxt_bit       = bit_cnt_reg + `ADCSF_STEP;
    want_dec      = (nxt_bit >= `ADCSF_BIT_SAMPLE_END) &&
                    (nxt_bit <= `ADCSF_BIT_LAST_DEC);
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    sar_idx_next  = sar_idx_reg;
    fs_first_next = fs_first_reg;
    spi_next      = spi_mode_out;
    data_next     = serial_data_out;
    oe_next       = serial_data_oe_out;
    pd_next       = powerdown_out;
    sample_next   = sample_out;
    dac_next      = dac_code_out;
    result_next   = result_out;
    rvalid_next   = 1'b0;
    push          = 1'b0;
    pop           = 1'b0;
    flush         = 1'b0;
    if (sel_n_s) begin
      state_next  = `ADCSF_ST_OFF;
      oe_next     = 1'b0;
      data_next   = 1'b0;
      pd_next     = 1'b1;
      sample_next = 1'b0;
      flush       = 1'b1;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (sel_fall) begin
            fs_first_next = fs_s;
            state_next    = `ADCSF_ST_MODE;
          end
        end
        ST_MODE: begin
          spi_next = fs_first_reg & fs_s;
          if (fs_first_reg & fs_s) begin
            oe_next    = 1'b1;
            data_next  = 1'b0;
            state_next = `ADCSF_ST_PDN;
          end else begin
            state_next = `ADCSF_ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (sclk_fall & fs_s) begin
            state_next  = `ADCSF_ST_RESET;
            pd_next     = 1'b0;
            sample_next = 1'b1;
            oe_next     = 1'b1;
            data_next   = 1'b0;
            flush       = 1'b1;
          end
        end
        ST_RESET: begin
          if (sclk_fall & ~fs_s) begin
            state_next   = `ADCSF_ST_SHIFT;
            bit_cnt_next = `ADCSF_BIT_FIRST;
            sar_idx_next = `ADCSF_IDX_MSB;
            dac_next     = trial_mask(`ADCSF_IDX_MSB);
            data_next    = 1'b0;
          end
        end
        ST_SHIFT: begin
          if (sclk_fall & fs_s & ~spi_mode_out) begin
            state_next  = `ADCSF_ST_RESET;
            sample_next = 1'b1;
            data_next   = 1'b0;
            flush       = 1'b1;
          end else if (sclk_fall &&
                       bit_cnt_reg == `ADCSF_BIT_LAST) begin
            state_next = `ADCSF_ST_PDN;
            pd_next    = 1'b1;
          end else if (sclk_rise &&
                       bit_cnt_reg != `ADCSF_BIT_LAST &&
                       (!want_dec || buf_in_ready)) begin
            bit_cnt_next = nxt_bit;
            if (nxt_bit == `ADCSF_BIT_SAMPLE_END) begin
              sample_next = 1'b0;
            end
            if (want_dec) begin
              push = 1'b1;
              if (!cmp_s) begin
                dac_next = dac_code_out & ~trial_mask(sar_idx_reg);
              end
              if (sar_idx_reg != `ADCSF_IDX_LSB) begin
                sar_idx_next = sar_idx_reg - `ADCSF_STEP;
                dac_next = dac_next |
                           trial_mask(sar_idx_reg - `ADCSF_STEP);
              end else begin
                result_next = dac_next;
                rvalid_next = 1'b1;
              end
            end
            if (nxt_bit >= `ADCSF_BIT_RES_FIRST) begin
              pop       = 1'b1;
              data_next = buf_out_valid & buf_out_data;
            end else begin
              data_next = 1'b0;
            end
          end
        end
        ST_PDN: begin
          if (spi_mode_out) begin
            if (sclk_rise) begin
              state_next   = `ADCSF_ST_SHIFT;
              bit_cnt_next = `ADCSF_BIT_FIRST;
              sar_idx_next = `ADCSF_IDX_MSB;
              dac_next     = trial_mask(`ADCSF_IDX_MSB);
              pd_next      = 1'b0;
              sample_next  = 1'b1;
              data_next    = 1'b0;
              flush        = 1'b1;
            end
          end else if (sclk_fall & fs_s) begin
            // frame sync wakes, even on last bit
            state_next  = `ADCSF_ST_RESET;
            pd_next     = 1'b0;
            sample_next = 1'b1;
            oe_next     = 1'b1;
            data_next   = 1'b0;
            flush       = 1'b1;
          end else if (sclk_rise) begin
            // framed output released after the word
            oe_next   = 1'b0;
            data_next = 1'b0;
          end
        end
        default: begin
          state_next = `ADCSF_ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // select reaches us through the synchroniser, so release and
  // powerdown follow it within three clocks rather than at once
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg          <= `ADCSF_ST_OFF;
      bit_cnt_reg        <= `ADCSF_BIT_FIRST;
      sar_idx_reg        <= `ADCSF_IDX_MSB;
      fs_first_reg       <= 1'b0;
      spi_mode_out       <= 1'b0;
      serial_data_out    <= 1'b0;
      serial_data_oe_out <= 1'b0;
      powerdown_out      <= 1'b1;
      sample_out         <= 1'b0;
      dac_code_out       <= `ADCSF_CODE_ZERO;
      result_out         <= `ADCSF_CODE_ZERO;
      result_valid_out   <= 1'b0;
    end else begin
      state_reg          <= state_next;
      bit_cnt_reg        <= bit_cnt_next;
      sar_idx_reg        <= sar_idx_next;
      fs_first_reg       <= fs_first_next;
      spi_mode_out       <= spi_next;
      serial_data_out    <= data_next;
      serial_data_oe_out <= oe_next;
      powerdown_out      <= pd_next;
      sample_out         <= sample_next;
      dac_code_out       <= dac_next;
      result_out         <= result_next;
      result_valid_out   <= rvalid_next;
    end
  end

endmodule

// ---- logic/adcsf_defines.vh ----
// shared constants of the serial frame interface of the converter
`ifndef ADCSF_DEFINES_VH
`define ADCSF_DEFINES_VH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define ADCSF_RES_BITS      10
`define ADCSF_RES_MSB       9
`define ADCSF_CNT_BITS      4
`define ADCSF_STEP          4'h1
`define ADCSF_BIT_FIRST     4'h0
`define ADCSF_BIT_SAMPLE_END 4'h5
`define ADCSF_BIT_RES_FIRST 4'h6
`define ADCSF_BIT_LAST_DEC  4'hE
`define ADCSF_BIT_LAST      4'hF
`define ADCSF_IDX_MSB       4'h9
`define ADCSF_IDX_LSB       4'h0
`define ADCSF_CODE_ZERO     10'h000
`define ADCSF_CODE_ONE      10'h001

// ----------------------------------------------------------------
// control states
// ----------------------------------------------------------------
`define ADCSF_ST_BITS       3
`define ADCSF_ST_OFF        3'h0
`define ADCSF_ST_MODE       3'h1
`define ADCSF_ST_WAIT       3'h2
`define ADCSF_ST_RESET      3'h3
`define ADCSF_ST_SHIFT      3'h4
`define ADCSF_ST_PDN        3'h5

// ----------------------------------------------------------------
// buffer and synchroniser shape
// ----------------------------------------------------------------
`define ADCSF_BUF_WIDTH     1
`define ADCSF_SYNC_WIDTH    4

`endif

// ---- logic/adcsf_sync.v ----
// two-flop synchroniser for the pins from outside the clock domain
`timescale 1ns/1ns
module adcsf_sync #(
  parameter WIDTH = 4
) (
  input  wire             clock_in,
  input  wire             resetn_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ---- logic/adcsf_fifo2.v ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module adcsf_fifo2 #(
  parameter WIDTH = 1
) (
  input  wire             clock_in,
  input  wire             resetn_in,
  input  wire             flush_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;

  // storage needs no reset, count and pointers guard it
  always @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else if (flush_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ---- tb/adcsf_core_assertions.sv ----
// concurrent checks on the serial frame interface ports
`timescale 1ns/1ns
module adcsf_core_chk (
  input wire       clock_in,
  input wire       resetn_in,
  input wire       sclk_in,
  input wire       select_n_in,
  input wire       frame_sync_in,
  input wire       serial_data_out,
  input wire       serial_data_oe_out,
  input wire       powerdown_out,
  input wire       sample_out,
  input wire       spi_mode_out,
  input wire [9:0] result_out,
  input wire       result_valid_out
);
  // ------------------------------------------------------------
  // edge ages: pins pass a sync, so reactions trail by 3 clocks
  // ------------------------------------------------------------
  logic [3:0] rise_age_reg;
  logic [3:0] fall_age_reg;
  logic [3:0] fs_age_reg;
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rise_age_reg <= 4'hF;
      fall_age_reg <= 4'hF;
      fs_age_reg   <= 4'hF;
    end else begin
      rise_age_reg <= $rose(sclk_in) ? 4'h0 :
                      rise_age_reg + (rise_age_reg != 4'hF);
      fall_age_reg <= $fell(sclk_in) ? 4'h0 :
                      fall_age_reg + (fall_age_reg != 4'hF);
      fs_age_reg   <= frame_sync_in ? 4'h0 :
                      fs_age_reg + (fs_age_reg != 4'hF);
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence s_sel_fs(bit fs);
    $fell(select_n_in) && frame_sync_in == fs
      ##1 (!select_n_in && frame_sync_in == fs) [*4];
  endsequence
  sequence s_valid_once;
    result_valid_out ##1 !result_valid_out [*8];
  endsequence
  property p_idle;
    select_n_in [*6] |-> !serial_data_oe_out && powerdown_out && !sample_out;
  endproperty
  property p_release;
    $rose(select_n_in) |-> ##[1:5] (!serial_data_oe_out && powerdown_out);
  endproperty
  property p_oe_sel;
    serial_data_oe_out |-> !select_n_in || !$past(select_n_in, 5);
  endproperty
  property p_mode_framed;
    s_sel_fs(1'b0) |-> ##6 !spi_mode_out;
  endproperty
  property p_mode_spi;
    s_sel_fs(1'b1) |-> ##6 spi_mode_out;
  endproperty
  property p_wake;
    $fell(powerdown_out) && !spi_mode_out |-> fs_age_reg < 4'h8;
  endproperty
  property p_sample_pd;
    sample_out |-> !powerdown_out;
  endproperty
  property p_sample_end;
    $fell(sample_out) |-> rise_age_reg < 4'h6 || select_n_in;
  endproperty
  property p_data_edge;
    $changed(serial_data_out) && $past(serial_data_oe_out) &&
      serial_data_oe_out && !frame_sync_in |-> rise_age_reg < 4'h6;
  endproperty
  property p_pd_edge;
    $rose(powerdown_out) && !select_n_in |-> fall_age_reg < 4'h6;
  endproperty
  property p_valid;
    $changed(result_out) |-> s_valid_once;
  endproperty
  a_idle: assert property (p_idle)
    else $error("output driven or awake while deselected");
  a_release: assert property (p_release)
    else $error("deselect did not release and power down");
  a_oe_sel: assert property (p_oe_sel)
    else $error("data pin driven long after deselect");
  a_mode_framed: assert property (p_mode_framed)
    else $error("framed mode not latched");
  a_mode_spi: assert property (p_mode_spi)
    else $error("three-wire mode not latched");
  a_wake: assert property (p_wake)
    else $error("framed wake without frame sync");
  a_sample_pd: assert property (p_sample_pd)
    else $error("sampling while powered down");
  a_sample_end: assert property (p_sample_end)
    else $error("sampling ended away from a clock rise");
  a_data_edge: assert property (p_data_edge)
    else $error("data changed away from a clock rise");
  a_pd_edge: assert property (p_pd_edge)
    else $error("powerdown entered away from a clock fall");
  a_valid: assert property (p_valid)
    else $error("result update without single valid pulse");
endmodule
bind adcsf_core adcsf_core_chk chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .sclk_in(sclk_in),
  .select_n_in(select_n_in), .frame_sync_in(frame_sync_in),
  .serial_data_out(serial_data_out),
  .serial_data_oe_out(serial_data_oe_out),
  .powerdown_out(powerdown_out), .sample_out(sample_out),
  .spi_mode_out(spi_mode_out), .result_out(result_out),
  .result_valid_out(result_valid_out)
);

// ---- tb/adcsf_host_model.sv ----
// host side: serial port master plus analog comparator
`timescale 1ns/1ns
module adcsf_host_model (
  input  wire       clock_in,
  input  wire       sd_in,
  input  wire       sd_oe_in,
  input  wire [9:0] dac_code_in,
  output logic      sclk_out,
  output logic      select_n_out,
  output logic      frame_sync_out,
  output logic      compare_out
);
  logic [9:0] ain;
  logic [9:0] ain_q[$];
  logic       cap[$];
  logic       last_reg;
  logic       spi;
  int         cyc;
  wire        pin;
  // released line shows the inverse, so no stale bit passes
  assign pin = sd_oe_in ? sd_in : ~last_reg;
  initial begin
    sclk_out       = 1'b0;
    select_n_out   = 1'b1;
    frame_sync_out = 1'b0;
    compare_out    = 1'b0;
    last_reg       = 1'b0;
    ain            = 10'h000;
    spi            = 1'b0;
  end
  always @(posedge clock_in) begin
    if (sd_oe_in)
      last_reg <= sd_in;
    compare_out <= ain >= dac_code_in;
  end
  // frame sync level at select fall
  task sel(input logic lvl, input logic fs, input logic fs2);
    @(posedge clock_in);
    select_n_out   <= lvl;
    frame_sync_out <= fs;
    @(posedge clock_in);
    frame_sync_out <= fs2;
    spi = fs & fs2;
    cyc = 0;
    repeat (8) @(posedge clock_in);
  endtask
  task burst(input int n, input logic [63:0] fs_mask);
    for (int c = 0; c < n; c++) begin
      if ((spi ? cyc % 16 == 0 : fs_mask[c]) && ain_q.size() > 0)
        ain = ain_q.pop_front();
      cyc++;
      sclk_out       <= 1'b1;
      frame_sync_out <= spi | fs_mask[c];
      #62;
      sclk_out <= 1'b0;
      cap.push_back(pin);
      #63;
    end
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench of the serial frame interface
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  logic        clock_in;
  logic        resetn_in;
  wire         sclk;
  wire         select_n;
  wire         frame_sync;
  wire         compare;
  wire         sd;
  wire         sd_oe;
  wire         pd;
  wire         sample;
  wire         spi_mode;
  wire  [9:0]  dac;
  wire  [9:0]  result;
  wire         valid;
  int          n_mismatch;
  int          tests_run;
  int          n_valid;
  logic [15:0] lfsr_reg;
  logic [9:0]  c0;
  logic [9:0]  c1;
  adcsf_core uut (
    .clock_in           (clock_in),
    .resetn_in          (resetn_in),
    .sclk_in            (sclk),
    .select_n_in        (select_n),
    .frame_sync_in      (frame_sync),
    .compare_in         (compare),
    .serial_data_out    (sd),
    .serial_data_oe_out (sd_oe),
    .powerdown_out      (pd),
    .sample_out         (sample),
    .spi_mode_out       (spi_mode),
    .dac_code_out       (dac),
    .result_out         (result),
    .result_valid_out   (valid)
  );
  adcsf_host_model host (
    .clock_in       (clock_in),
    .sd_in          (sd),
    .sd_oe_in       (sd_oe),
    .dac_code_in    (dac),
    .sclk_out       (sclk),
    .select_n_out   (select_n),
    .frame_sync_out (frame_sync),
    .compare_out    (compare)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] word_of(input logic [9:0] code);
    return {6'h00, code};
  endfunction
  task pick(output logic [9:0] c);
    lfsr_reg = lfsr(lfsr_reg);
    c = lfsr_reg[9:0];
    host.ain_q.push_back(c);
  endtask
  task chk_word(input int base, input logic [9:0] code);
    logic [15:0] got;
    for (int i = 0; i < 16; i++)
      got[15-i] = host.cap[base+i];
    `CHK(got, word_of(code))
  endtask
  task start(input int n, input logic [63:0] m);
    host.cap.delete();
    n_valid = 0;
    host.burst(n, m);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
    if (valid === 1'b1)
      n_valid++;
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    lfsr_reg = 16'h0045;
    resetn_in = 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    `CHK({sd_oe, pd, sample, spi_mode, result, valid}, 15'h2000)
    host.sel(1'b0, 1'b0, 1'b0);
    host.burst(4, 64'h0);
    `CHK({sd_oe, pd, spi_mode}, 3'b010)
    pick(c0);
    start(18, 64'h1);
    chk_word(1, c0);
    `CHK(result, c0)
    `CHK({pd, sd_oe, n_valid[1:0]}, 4'b1001)
    host.ain_q.push_back(10'h3FF);
    host.ain_q.push_back(10'h000);
    pick(c0);
    start(49, 64'h1_0001_0001);
    chk_word(1, 10'h3FF);
    chk_word(17, 10'h000);
    chk_word(33, c0);
    `CHK(n_valid, 3)
    pick(c0);
    pick(c1);
    start(28, 64'h801);
    chk_word(12, c1);
    `CHK(n_valid, 1)
    pick(c0);
    start(9, 64'h1);
    host.sel(1'b1, 1'b0, 1'b0);
    `CHK({sd_oe, pd, sample, result}, {3'b010, c1})
    host.sel(1'b0, 1'b1, 1'b1);
    `CHK({spi_mode, sd_oe, pd}, 3'b111)
    pick(c0);
    pick(c1);
    start(8, 64'h0);
    repeat (40) @(posedge clock_in);
    host.burst(8, 64'h0);
    `CHK(pd, 1'b1)
    host.burst(16, 64'h0);
    chk_word(0, c0);
    chk_word(16, c1);
    `CHK(n_valid, 2)
    host.sel(1'b1, 1'b1, 1'b1);
    host.sel(1'b0, 1'b1, 1'b0);
    `CHK(spi_mode, 1'b0)
    pick(c0);
    start(18, 64'h1);
    chk_word(1, c0);
    close_out;
  end
endmodule
